//--- verilog/dual_timer_pkg.sv
`default_nettype none
// Functional notes
// - Width mode counts only at measured level.
// - Count source is oscillator divided by sixteen.
// - Timer X underflows after zero, then reloads.
// - Edge bit picks measured level and edge.
// - Active measured edge sets capture request X.
// - Timer X underflow sets request, enable gates.
// - Capture request clears by zero write, acceptance.
// - Underflow drives preset data onto output pins.
// - Output starts once port control bit set.
// - Rewritten data appears at next underflow.
// - Output 0 from bit 2, 1 from bit 3.
// - Timer Y stop bit resets to zero.
// - Writing one to stop bit halts counting.
// - Timer Y underflows, reloads, sets request.
// - Period edge reloads; old count held until read.
// - Bit 6 chooses falling or rising period.
// - Period mode also reloads on underflow.
// - Period edge sets capture request Y.
// - Event mode decrements and flags on edges.
// - Write loads latch and counter unless latch-only.
package dual_timer_pkg;

  localparam int TMR_W        = 16;
  localparam int PRESCALE_DIV = 16;

  // Byte offsets within the slave's window.
  localparam logic [7:0] OFS_TX      = 8'h00;
  localparam logic [7:0] OFS_TY      = 8'h04;
  localparam logic [7:0] OFS_TX_MODE = 8'h08;
  localparam logic [7:0] OFS_TY_MODE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_REQ = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h14;
  localparam logic [7:0] OFS_CLK     = 8'h18;

  // Values after reset.
  localparam logic [31:0] TMR_RST  = 32'h0000FFFF;
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [3:0]  IRQ_RST  = 4'h0;
  localparam logic        HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    X_TIMER     = 2'b00,
    X_PULSE_OUT = 2'b01,
    X_EVENT     = 2'b10,
    X_WIDTH     = 2'b11
  } x_mode_t;

  typedef enum logic [1:0] {
    Y_TIMER    = 2'b00,
    Y_PERIOD   = 2'b01,
    Y_EVENT    = 2'b10,
    Y_WIDTH_HL = 2'b11
  } y_mode_t;

  typedef struct packed {
    logic    stop;
    logic    edge_sel;
    x_mode_t mode;
    logic    realtime_out_1_data;
    logic    realtime_out_0_data;
    logic    rtp_en;
    logic    latch_only;
  } tx_mode_t;

  typedef struct packed {
    logic       stop;
    logic       edge_sel;
    y_mode_t    mode;
    logic [3:0] rsvd;
  } ty_mode_t;

  typedef struct packed {
    logic y_cap;
    logic y_unf;
    logic x_cap;
    logic x_unf;
  } irq_bits_t;

endpackage : dual_timer_pkg
`default_nettype wire

//--- verilog/count_prescaler.sv
`default_nettype none
module count_prescaler #(
  parameter int DIV = dual_timer_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Oscillator inputs
  input  wire logic main_osc_in,
  input  wire logic sub_osc_in,
  input  wire logic low_speed,
  // Count pulse
  output      logic tick
);
  import dual_timer_pkg::*;

  localparam int CW = (DIV < 2) ? 1 : $clog2(DIV);

  if (DIV < 2)
  begin : g_bad_div
    $error("count_prescaler needs DIV of at least 2");
  end

  logic          osc_prev_ff;
  logic [CW-1:0] div_cnt_ff;
  logic          osc_sel;
  logic          osc_rise;

  always_comb
  begin
    osc_sel  = low_speed ? sub_osc_in : main_osc_in;
    osc_rise = osc_sel & ~osc_prev_ff;
    tick     = osc_rise & (div_cnt_ff == CW'(DIV - 1));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      osc_prev_ff <= 1'b0;
    else
      osc_prev_ff <= osc_sel;
  end

  // Switching source mid-count only lengthens or shortens one period.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_cnt_ff <= '0;
    else if (tick)
      div_cnt_ff <= '0;
    else if (osc_rise)
      div_cnt_ff <= div_cnt_ff + 1'b1;
  end

endmodule : count_prescaler
`default_nettype wire

//--- verilog/pin_edge_detect.sv
`default_nettype none
module pin_edge_detect (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic rising_sel,
  output      logic active_edge
);
  import dual_timer_pkg::*;

  logic prev_ff;
  logic primed_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_ff <= 1'b0;
    else
      prev_ff <= pin;
  end

  // The first sample only primes the history, so a pin that is already
  // high at reset release is not mistaken for a rising edge.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      primed_ff <= 1'b0;
    else
      primed_ff <= 1'b1;
  end

  always_comb
  begin
    active_edge = primed_ff &
                  (rising_sel ? (pin & ~prev_ff) : (~pin & prev_ff));
  end

endmodule : pin_edge_detect
`default_nettype wire

//--- verilog/dual_timer_measure_rtport.sv
`default_nettype none
module dual_timer_measure_rtport #(
  parameter int TIMER_W = dual_timer_pkg::TMR_W
) (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output      logic                      hreadyout,
  output      logic [31:0]               hrdata,
  output      logic                      hresp,
  // Count source oscillators
  input  wire logic                      main_osc_in,
  input  wire logic                      sub_osc_in,
  // Capture pins
  input  wire logic                      timer_x_capture_pin,
  input  wire logic                      timer_y_capture_pin,
  // Real-time outputs
  output      logic                      realtime_out_0,
  output      logic                      realtime_out_1,
  // Interrupt requests and acceptance
  output      dual_timer_pkg::irq_bits_t irq,
  input  wire dual_timer_pkg::irq_bits_t irq_ack
);
  import dual_timer_pkg::*;

  if (TIMER_W < 2 || TIMER_W > 31)
  begin : g_bad_width
    $error("TIMER_W must lie between 2 and 31");
  end

  function automatic logic [31:0] zx(input logic [TIMER_W-1:0] v);
    zx = {{(32 - TIMER_W){1'b0}}, v};
  endfunction : zx

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic               acc;
  logic               wr_ph_ff;
  logic [7:0]         addr_ph_ff;
  logic               wr_tx, wr_ty, wr_txm, wr_tym;
  logic               wr_req, wr_en, wr_clk, rd_ty;
  tx_mode_t           tx_mode_ff;
  ty_mode_t           ty_mode_ff;
  irq_bits_t          irq_req_ff, irq_en_ff;
  irq_bits_t          irq_set, irq_clr, nxt_irq_req;
  logic               low_speed_ff;
  logic [TIMER_W-1:0] x_cnt_ff, x_latch_ff;
  logic [TIMER_W-1:0] y_cnt_ff, y_latch_ff, y_hold_ff;
  logic               y_hold_vld_ff;
  logic               cnt_pulse, x_edge, y_edge;
  logic               x_level_ok, x_tick, x_unf;
  logic               y_tick, y_unf, y_reload_edge;
  logic [31:0]        nxt_hrdata;

  // Bus pipeline: address phase is captured, data phase acts next cycle.
  always_comb
  begin
    acc    = hsel & htrans[1] & hready;
    wr_tx  = wr_ph_ff & hit(addr_ph_ff, OFS_TX);
    wr_ty  = wr_ph_ff & hit(addr_ph_ff, OFS_TY);
    wr_txm = wr_ph_ff & hit(addr_ph_ff, OFS_TX_MODE);
    wr_tym = wr_ph_ff & hit(addr_ph_ff, OFS_TY_MODE);
    wr_req = wr_ph_ff & hit(addr_ph_ff, OFS_IRQ_REQ);
    wr_en  = wr_ph_ff & hit(addr_ph_ff, OFS_IRQ_EN);
    wr_clk = wr_ph_ff & hit(addr_ph_ff, OFS_CLK);
    rd_ty  = acc & ~hwrite & hit(haddr[7:0], OFS_TY);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_ff   <= 1'b0;
      addr_ph_ff <= 8'h00;
    end
    else
    begin
      wr_ph_ff <= acc & hwrite;
      if (acc)
        addr_ph_ff <= haddr[7:0];
    end
  end

  // Zero wait states and an OKAY answer to every access.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  always_comb
  begin
    case (haddr[7:0])
      OFS_TX:      nxt_hrdata = zx(x_cnt_ff);
      OFS_TY:      nxt_hrdata = y_hold_vld_ff ? zx(y_hold_ff)
                                              : zx(y_cnt_ff);
      OFS_TX_MODE: nxt_hrdata = {24'h000000, tx_mode_ff};
      OFS_TY_MODE: nxt_hrdata = {24'h000000, ty_mode_ff};
      OFS_IRQ_REQ: nxt_hrdata = {28'h0000000, irq_req_ff};
      OFS_IRQ_EN:  nxt_hrdata = {28'h0000000, irq_en_ff};
      OFS_CLK:     nxt_hrdata = {31'h00000000, low_speed_ff};
      default:     nxt_hrdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (acc & ~hwrite)
      hrdata <= nxt_hrdata;
  end

  // Control registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_mode_ff   <= tx_mode_t'(MODE_RST);
      ty_mode_ff   <= ty_mode_t'(MODE_RST);
      irq_en_ff    <= irq_bits_t'(IRQ_RST);
      low_speed_ff <= 1'b0;
    end
    else
    begin
      if (wr_txm)
        tx_mode_ff <= tx_mode_t'(hwdata[7:0]);
      if (wr_tym)
        ty_mode_ff <= ty_mode_t'({hwdata[7:4], 4'h0});
      if (wr_en)
        irq_en_ff <= irq_bits_t'(hwdata[3:0]);
      if (wr_clk)
        low_speed_ff <= hwdata[0];
    end
  end

  count_prescaler #(
    .DIV (PRESCALE_DIV)
  ) u_prescaler (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .main_osc_in (main_osc_in),
    .sub_osc_in  (sub_osc_in),
    .low_speed   (low_speed_ff),
    .tick        (cnt_pulse)
  );

  pin_edge_detect u_x_edge (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (timer_x_capture_pin),
    .rising_sel  (tx_mode_ff.edge_sel),
    .active_edge (x_edge)
  );

  pin_edge_detect u_y_edge (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (timer_y_capture_pin),
    .rising_sel  (ty_mode_ff.edge_sel),
    .active_edge (y_edge)
  );

  // Timer X. Modes other than width measurement count as a plain timer.
  always_comb
  begin
    x_level_ok = (timer_x_capture_pin == ~tx_mode_ff.edge_sel);
    x_tick     = cnt_pulse & ~tx_mode_ff.stop &
                 ((tx_mode_ff.mode != X_WIDTH) | x_level_ok);
    x_unf      = x_tick & (x_cnt_ff == '0);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      x_latch_ff <= TMR_RST[TIMER_W-1:0];
    else if (wr_tx)
      x_latch_ff <= hwdata[TIMER_W-1:0];
  end

  // A software write outranks a count in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      x_cnt_ff <= TMR_RST[TIMER_W-1:0];
    else if (wr_tx & ~tx_mode_ff.latch_only)
      x_cnt_ff <= hwdata[TIMER_W-1:0];
    else if (x_unf)
      x_cnt_ff <= x_latch_ff;
    else if (x_tick)
      x_cnt_ff <= x_cnt_ff - 1'b1;
  end

  // Real-time port; the pins follow the data bits only at underflow.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      realtime_out_0 <= 1'b0;
      realtime_out_1 <= 1'b0;
    end
    else if (x_unf & tx_mode_ff.rtp_en)
    begin
      realtime_out_0 <= tx_mode_ff.realtime_out_0_data;
      realtime_out_1 <= tx_mode_ff.realtime_out_1_data;
    end
  end

  // Timer Y. Width HL mode counts as a plain timer.
  always_comb
  begin
    y_tick        = ~ty_mode_ff.stop &
                    ((ty_mode_ff.mode == Y_EVENT) ? y_edge
                                                  : cnt_pulse);
    y_unf         = y_tick & (y_cnt_ff == '0);
    y_reload_edge = ~ty_mode_ff.stop & y_edge &
                    (ty_mode_ff.mode == Y_PERIOD);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      y_latch_ff <= TMR_RST[TIMER_W-1:0];
    else if (wr_ty)
      y_latch_ff <= hwdata[TIMER_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      y_cnt_ff <= TMR_RST[TIMER_W-1:0];
    else if (wr_ty)
      y_cnt_ff <= hwdata[TIMER_W-1:0];
    else if (y_reload_edge | y_unf)
      y_cnt_ff <= y_latch_ff;
    else if (y_tick)
      y_cnt_ff <= y_cnt_ff - 1'b1;
  end

  // The held count survives further edges until one read has taken it.
  // Because a word read is atomic, both bytes always come from one value.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      y_hold_ff     <= '0;
      y_hold_vld_ff <= 1'b0;
    end
    else if (y_reload_edge & (~y_hold_vld_ff | rd_ty))
    begin
      y_hold_ff     <= y_cnt_ff;
      y_hold_vld_ff <= 1'b1;
    end
    else if (rd_ty)
      y_hold_vld_ff <= 1'b0;
  end

  // Request flags: a set in the same cycle as a clear wins.
  always_comb
  begin
    irq_set.x_unf = x_unf;
    irq_set.x_cap = x_edge & (tx_mode_ff.mode == X_WIDTH);
    irq_set.y_unf = y_unf;
    irq_set.y_cap = y_edge & ((ty_mode_ff.mode == Y_PERIOD) |
                              (ty_mode_ff.mode == Y_EVENT));
    irq_clr       = irq_bits_t'(irq_ack & irq_en_ff);
    if (wr_req)
      irq_clr = irq_bits_t'(irq_clr | ~hwdata[3:0]);
    nxt_irq_req = irq_bits_t'((irq_req_ff & ~irq_clr) | irq_set);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req_ff <= irq_bits_t'(IRQ_RST);
      irq        <= irq_bits_t'(IRQ_RST);
    end
    else
    begin
      irq_req_ff <= nxt_irq_req;
      irq        <= irq_bits_t'(nxt_irq_req & irq_en_ff);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_width_hold:
  assert property ((tx_mode_ff.mode == X_WIDTH) && !x_level_ok && !wr_tx
                   |=> $stable(x_cnt_ff))
  else $error("timer X counted outside the measured level");
  a_prescale_gap:
  assert property (cnt_pulse |=> !cnt_pulse [*8])
  else $error("count pulses closer than the divider allows");
  a_x_reload:
  assert property (x_unf && !wr_tx |=> x_cnt_ff == $past(x_latch_ff))
  else $error("timer X did not reload from its latch");
  a_x_cap_flag:
  assert property (x_edge && (tx_mode_ff.mode == X_WIDTH)
                   |=> irq_req_ff.x_cap)
  else $error("capture edge on X did not set its request");
  a_x_unf_irq:
  assert property (x_unf && irq_en_ff.x_unf && !wr_en
                   |=> irq_req_ff.x_unf && irq.x_unf)
  else $error("timer X underflow did not raise its request");
  a_ack_clear:
  assert property (irq_ack.x_cap && irq_en_ff.x_cap && !irq_set.x_cap
                   |=> !irq_req_ff.x_cap)
  else $error("accepted capture request was not cleared");
  a_rtp_update:
  assert property (x_unf && tx_mode_ff.rtp_en
                   |=> realtime_out_0 == $past(tx_mode_ff.realtime_out_0_data) &&
                       realtime_out_1 == $past(tx_mode_ff.realtime_out_1_data))
  else $error("real-time pins missed the underflow update");
  a_rtp_steady:
  assert property (!(x_unf && tx_mode_ff.rtp_en)
                   |=> $stable(realtime_out_0) && $stable(realtime_out_1))
  else $error("real-time pins changed without an underflow");
  a_y_stop_hold:
  assert property (ty_mode_ff.stop && !wr_ty |=> $stable(y_cnt_ff))
  else $error("timer Y moved while stopped");
  a_y_unf_reload:
  assert property (y_unf && !wr_ty
                   |=> y_cnt_ff == $past(y_latch_ff) && irq_req_ff.y_unf)
  else $error("timer Y underflow lacked reload or request");

  a_y_period_hold:
  assert property (y_reload_edge && !y_hold_vld_ff
                   |=> y_hold_vld_ff && y_hold_ff == $past(y_cnt_ff))
  else $error("period edge did not hold the old count");

  a_y_event_dec:
  assert property ((ty_mode_ff.mode == Y_EVENT) && !ty_mode_ff.stop &&
                   y_edge && (y_cnt_ff != '0) && !wr_ty
                   |=> y_cnt_ff == $past(y_cnt_ff) - 1'b1)
  else $error("event edge did not decrement timer Y");

  a_tx_write:
  assert property (wr_tx && !tx_mode_ff.latch_only
                   |=> x_cnt_ff == $past(hwdata[TIMER_W-1:0]))
  else $error("timer X write did not load the counter");

endmodule : dual_timer_measure_rtport
`default_nettype wire

//--- tb/ext_pulse_source.sv
`default_nettype none
module ext_pulse_source #(
  parameter int MAIN_HALF = 2,
  parameter int SUB_HALF  = 8
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Commanded pin levels
  input  wire logic x_level,
  input  wire logic y_level,
  // Real-time output loads, port direction taken as output
  input  wire logic rt_0,
  input  wire logic rt_1,
  // Pins towards the block
  output var  logic main_osc_in,
  output var  logic sub_osc_in,
  output var  logic timer_x_capture_pin,
  output var  logic timer_y_capture_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt_ff;
  // Both oscillators run free, far slower than hclk so sampling is safe.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff              <= 0;
      main_osc_in         <= 1'b0;
      sub_osc_in          <= 1'b0;
      timer_x_capture_pin <= 1'b0;
      timer_y_capture_pin <= 1'b0;
    end
    else
    begin
      cnt_ff              <= cnt_ff + 1;
      main_osc_in         <= 1'((cnt_ff / MAIN_HALF) % 2);
      sub_osc_in          <= 1'((cnt_ff / SUB_HALF) % 2);
      timer_x_capture_pin <= x_level;
      timer_y_capture_pin <= y_level;
    end
  end
endmodule : ext_pulse_source
`default_nettype wire

//--- tb/test_dual_timer_measure_rtport.sv
`default_nettype none
module test_dual_timer_measure_rtport;
  timeunit 1ns;
  timeprecision 1ns;
  import dual_timer_pkg::*;
  localparam int TICK  = 2 * 2 * PRESCALE_DIV;
  localparam int LTICK = 2 * 8 * PRESCALE_DIV;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        x_lvl = 0, y_lvl = 0, rd_phase = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, rt0, rt1, mosc, sosc, xpin, ypin;
  irq_bits_t   irq, irq_ack = '0;
  int          num_errors = 0, checks_done = 0;
  logic [63:0] expq[$];
  always #50 hclk = ~hclk;

  dual_timer_measure_rtport i_dual_timer_measure_rtport (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .main_osc_in(mosc), .sub_osc_in(sosc),
    .timer_x_capture_pin(xpin), .timer_y_capture_pin(ypin),
    .realtime_out_0(rt0), .realtime_out_1(rt1),
    .irq(irq), .irq_ack(irq_ack));
  ext_pulse_source i_ext_pulse_source (
    .hclk(hclk), .hresetn(hresetn), .x_level(x_lvl), .y_level(y_lvl),
    .rt_0(rt0), .rt_1(rt1), .main_osc_in(mosc), .sub_osc_in(sosc),
    .timer_x_capture_pin(xpin), .timer_y_capture_pin(ypin));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic cmp(string n, logic [31:0] lo, hi, seen);
    checks_done++;
    if ((seen >= lo && seen <= hi) !== 1'b1)
    begin
      num_errors++;
      $display("mismatch %s expected %h..%h seen %h", n, lo, hi, seen);
    end
  endtask : cmp

  task automatic cmp_bit(string n, logic e, logic s);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask : cmp_bit

  // Read data is judged here, at the edge that closes the data phase.
  always @(posedge hclk)
  begin
    logic [63:0] e;
    if (rd_phase && hreadyout === 1'b1)
    begin
      e = expq.pop_front();
      cmp("hrdata", e[63:32], e[31:0], hrdata);
      cmp_bit("hresp", HRESP_OKAY, hresp);
    end
  end

  task automatic edge_ready();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 100);
    if (hreadyout !== 1'b1)
    begin
      num_errors++;
      end_of_test();
    end
  endtask : edge_ready

  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, lo, hi);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    if (!w)
      expq.push_back({lo, hi});
    edge_ready();
    hsel     <= 1'b0;
    htrans   <= 2'b00;
    hwdata   <= d;
    rd_phase <= !w;
    edge_ready();
    rd_phase <= 1'b0;
  endtask : bus

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] lo, hi);
    bus(1'b0, a, 32'h0, lo, hi);
  endtask : rd

  // Two edges first, so a request cleared just before has left irq.
  task automatic wait_irq(int b, int lo, int hi);
    int n;
    n = 2;
    repeat (2) @(posedge hclk);
    while (irq[b] !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
    cmp("irq cycles", 32'(lo), 32'(hi), 32'(n));
    if (n >= 2000)
      end_of_test();
  endtask : wait_irq

  task automatic ypulse(int k);
    repeat (k)
    begin
      @(posedge hclk) y_lvl <= 1'b1;
      repeat (3) @(posedge hclk);
      y_lvl <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask : ypulse

  initial
  begin
    int k;
    void'($urandom(26812));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_TY_MODE, 32'h0, 32'h0);
    rd(OFS_IRQ_REQ, 32'h0, 32'h0);
    rd(8'h1C, 32'h0, 32'h0);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_TX_MODE, 32'h06);
    wr(OFS_TX, 32'h3);
    wait_irq(0, 3 * TICK, 4 * TICK + 8);
    cmp_bit("rt0", 1'b1, rt0);
    cmp_bit("rt1", 1'b0, rt1);
    wr(OFS_TX_MODE, 32'h0A);
    cmp_bit("rt0", 1'b1, rt0);
    wr(OFS_IRQ_REQ, 32'hE);
    wait_irq(0, 2 * TICK, 4 * TICK + 8);
    cmp_bit("rt0", 1'b0, rt0);
    cmp_bit("rt1", 1'b1, rt1);
    // Pulse width on timer X, high level measured first.
    wr(OFS_IRQ_REQ, 32'h0);
    wr(OFS_TX_MODE, 32'h30);
    wr(OFS_TX, 32'h100);
    repeat (3 * TICK) @(posedge hclk);
    rd(OFS_TX, 32'h100, 32'h100);
    x_lvl <= 1'b1;
    repeat (5 * TICK) @(posedge hclk);
    x_lvl <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(OFS_TX, 32'hFA, 32'hFC);
    rd(OFS_IRQ_REQ, 32'h2, 32'h2);
    wr(OFS_IRQ_REQ, 32'hD);
    rd(OFS_IRQ_REQ, 32'h0, 32'h0);
    wr(OFS_IRQ_EN, 32'h2);
    wr(OFS_TX_MODE, 32'h70);
    @(posedge hclk) x_lvl <= 1'b1;
    repeat (4) @(posedge hclk);
    cmp_bit("irq x_cap", 1'b1, irq.x_cap);
    irq_ack.x_cap <= 1'b1;
    @(posedge hclk) irq_ack <= '0;
    // Latch-only write must leave the frozen counter untouched.
    wr(OFS_TX_MODE, 32'h71);
    wr(OFS_TX, 32'h40);
    rd(OFS_TX, 32'hF9, 32'hFC);
    rd(OFS_IRQ_REQ, 32'h0, 32'h0);
    // Event counting on timer Y, then the same with the stop bit set.
    wr(OFS_TY_MODE, 32'h20);
    wr(OFS_TY, 32'h50);
    wr(OFS_IRQ_REQ, 32'h0);
    k = $urandom_range(8, 1);
    ypulse(k);
    repeat (3) @(posedge hclk);
    rd(OFS_TY, 32'(32'h50 - k), 32'(32'h50 - k));
    rd(OFS_IRQ_REQ, 32'h8, 32'h8);
    wr(OFS_TY_MODE, 32'hA0);
    ypulse(2);
    repeat (3) @(posedge hclk);
    rd(OFS_TY, 32'(32'h50 - k), 32'(32'h50 - k));
    // Rising-edge period; the falling edge between must not reload.
    wr(OFS_TY_MODE, 32'h50);
    wr(OFS_TY, 32'h200);
    wr(OFS_IRQ_REQ, 32'h0);
    @(posedge hclk) y_lvl <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(OFS_TY, 32'h1FE, 32'h200);
    @(posedge hclk) y_lvl <= 1'b0;
    repeat (10 * TICK) @(posedge hclk);
    y_lvl <= 1'b1;
    repeat (3 * TICK) @(posedge hclk);
    rd(OFS_TY, 32'h1F4, 32'h1F7);
    rd(OFS_TY, 32'h1FB, 32'h1FE);
    rd(OFS_IRQ_REQ, 32'h8, 32'h8);
    wr(OFS_IRQ_EN, 32'h4);
    wr(OFS_TY, 32'h2);
    wait_irq(2, 2 * TICK, 3 * TICK + 8);
    rd(OFS_TY, 32'h2, 32'h2);
    // Low-speed source: ticks come only every LTICK cycles.
    wr(OFS_CLK, 32'h1);
    wr(OFS_TY_MODE, 32'h0);
    wr(OFS_TY, 32'h1);
    wr(OFS_IRQ_REQ, 32'h0);
    wait_irq(2, LTICK - 16, 2 * LTICK + 8);
    end_of_test();
  end
endmodule : test_dual_timer_measure_rtport
`default_nettype wire
